/* rtl/pcg_pkg.sv */
// Shared constants for the programmable checksum generator and its host.
// Assumes one 200 MHz clock (core_clk) and a 16-bit register path.
`default_nettype none
package pcg_pkg;
    localparam int unsigned DATA_W = 16; // Register and widest word width
    localparam int unsigned ADDR_W = 2; // Register index width
    // Device register indices on the carrier
    localparam logic [1:0] ADDR_CTRL = 2'h0; // checksum_control
    localparam logic [1:0] ADDR_TAPS = 2'h1; // polynomial_taps
    localparam logic [1:0] ADDR_RESULT = 2'h2; // result_register
    localparam logic [1:0] ADDR_DATA = 2'h3; // data_write_port
    // checksum_control field positions
    localparam int unsigned CTRL_SIDL = 13; // stop_in_idle
    localparam int unsigned CTRL_CNT_LSB = 8; // valid_word_count lsb
    localparam int unsigned CTRL_CNT_MSB = 12; // valid_word_count msb
    localparam int unsigned CTRL_FULL = 7; // fifo_full_flag
    localparam int unsigned CTRL_EMPTY = 6; // fifo_empty_flag
    localparam int unsigned CTRL_GO = 4; // shift_start
    localparam int unsigned CTRL_POLY_LENGTH_MINUS_ONE_MSB = 3; // poly_length_minus_one msb
    // FIFO depth selection
    localparam logic [3:0] POLY_LENGTH_MINUS_ONE_SHORT_MAX = 4'h7; // Longest length with deep FIFO
    localparam logic [4:0] DEPTH_LONG = 5'h08; // Depth for long polynomials
    localparam logic [4:0] DEPTH_SHORT = 5'h10; // Depth for short polynomials
    localparam logic [3:0] PTR_MASK_LONG = 4'h7; // Pointer wrap, 8 deep
    localparam logic [3:0] PTR_MASK_SHORT = 4'hF; // Pointer wrap, 16 deep
    localparam logic [3:0] POLY_LENGTH_MINUS_ONE_TOP = 4'hF; // Largest length field
    localparam logic [15:0] ONES = 16'hFFFF; // Full-width mask
    // Host command indices on its own user port
    localparam logic [1:0] HCMD_CFG = 2'h0; // Write config, read status
    localparam logic [1:0] HCMD_TAPS = 2'h1; // Write taps, read result
    localparam logic [1:0] HCMD_WORD = 2'h2; // Queue one data word
    localparam logic [1:0] HCMD_FINISH = 2'h3; // Drain and fetch result
    localparam logic [3:0] SETTLE_CYC = 4'h8; // Tail shift time, worst case
endpackage
`default_nettype wire

/* rtl/pcg_if.sv */
// Register carrier between the processor-side host and the generator.
// Read data stands in the cycle after the read strobe, never stalls.
`default_nettype none
interface pcg_if;
    logic [1:0] addr; // Register index
    logic [15:0] wdata; // Write data
    logic [1:0] be; // Byte lane enables
    logic wr; // Write strobe
    logic rd; // Read strobe
    logic [15:0] rdata; // Read data, one cycle after rd
    modport dev (input addr, input wdata, input be, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output be, output wr, output rd, input rdata);
endinterface
`default_nettype wire

/* rtl/pcg_crc_step.sv */
// One serial feedback step of the checksum register.
// Assumes the length field is stable while the step is used.
`default_nettype none
module pcg_crc_step (
    input wire logic [15:0] crc_in, // Current register
    input wire logic [15:0] poly, // Enabled terms, bit 0 set
    input wire logic [3:0] poly_length_minus_one, // Length minus one
    input wire logic din, // Data bit
    output logic [15:0] crc_out // Register after one bit
);
    logic [15:0] msk; // Keeps only length bits
    logic fb; // Feedback bit from the top term

    // Top term is implied; taps fold feedback back in
    always_comb
    begin
        msk = pcg_pkg::ONES >> (pcg_pkg::POLY_LENGTH_MINUS_ONE_TOP - poly_length_minus_one);
        fb = crc_in[poly_length_minus_one] ^ din;
        crc_out = ((crc_in << 1) ^ (fb ? poly : 16'h0000)) & msk;
    end
endmodule
`default_nettype wire

/* rtl/pcg_dev.sv */
// Programmable checksum generator: registers, word FIFO, 2-bit/clk engine.
// Assumes the host keeps its own access rules; no bus waits ever.
// What this block does
// RULE1 - Four-bit length field holds length minus one
// RULE2 - Constant and top terms always in feedback
// RULE3 - Fifteen tap enables, bit zero reads zero
// RULE4 - Start bit runs shifter, zero stops it
// RULE5 - FIFO eight deep above seven, else sixteen
// RULE6 - Word is length bits, byte writes, excess ignored
// RULE7 - Count increments when most significant byte written
// RULE8 - Start and count nonzero load word, decrement
// RULE9 - Finishes half-length cycles after count hits zero
// RULE10 - Full at depth, empty at zero count
// RULE11 - Write when full wraps count, no interrupt
// RULE12 - Interrupt when count falls from one to zero
// RULE13 - Software waits for empty before reading result
// RULE14 - Software waits a cycle before reading count
// RULE15 - Software flushes by starting until empty
// RULE16 - Software primes FIFO, refills while below depth
// RULE17 - Sleep freezes state, resumes unchanged
// RULE18 - Idle stops only with stop_in_idle set
// RULE19 - Five-bit read-only valid word count
// RULE20 - Two bits per clock, msb first
//
// The implementer's own choices: strobed register access and the address map.
`default_nettype none
module pcg_dev (
    input wire logic core_clk, // 200 MHz clock
    input wire logic rst_b, // Async reset, active low
    pcg_if.dev bus, // Register carrier
    input wire logic sleep_mode, // Device asleep
    input wire logic idle_mode, // Device idle
    output logic crc_irq // One-cycle interrupt pulse
);
    typedef enum logic [1:0] {
        PCG_ENG_IDLE = 2'b01,
        PCG_ENG_SHIFT = 2'b10
    } pcg_eng_t;

    typedef struct packed {
        logic [15:0][15:0] fifo; // Word storage
        logic [3:0] wp; // Write pointer
        logic [3:0] rp; // Read pointer
        logic [4:0] cnt; // valid_word_count
        logic sidl; // stop_in_idle
        logic go; // shift_start
        logic [3:0] poly_length_minus_one; // poly_length_minus_one
        logic [15:1] taps; // polynomial_taps
        logic [15:0] stage; // Word being assembled from bytes
        pcg_eng_t eng; // Engine state
        logic [15:0] sh; // Word in engine, msb at top
        logic [4:0] left; // Bits still to shift
        logic [15:0] crc; // result_register
        logic [15:0] rdata; // Read data register
        logic irq; // Interrupt pulse
    } pcg_dev_st_t;

    pcg_dev_st_t s_r; // Registered state
    pcg_dev_st_t s_nxt; // Next state
    logic [15:0] crc_one; // After first bit
    logic [15:0] crc_two; // After second bit
    logic [15:0] poly; // Feedback terms

    // Constant term always fed back; top term implied in the step
    assign poly = {s_r.taps, 1'b1}; // RULE2

    // Two chained steps give two bits per clock
    pcg_crc_step u_step_a (
        .crc_in(s_r.crc),
        .poly(poly),
        .poly_length_minus_one(s_r.poly_length_minus_one),
        .din(s_r.sh[15]),
        .crc_out(crc_one)
    );
    pcg_crc_step u_step_b (
        .crc_in(crc_one),
        .poly(poly),
        .poly_length_minus_one(s_r.poly_length_minus_one),
        .din(s_r.sh[14]),
        .crc_out(crc_two)
    );

    // All next-state logic in one place
    always_comb
    begin
        logic long_poly; // Word wider than a byte
        logic [4:0] depth; // Current FIFO depth
        logic [3:0] pmask; // Pointer wrap mask
        logic [15:0] wmask; // Word width mask
        logic [15:0] stg; // Stage after this write
        logic msb_lane; // Lane holding the word msb
        logic push; // Word completes this cycle
        logic pop; // Word moves to engine
        logic wrap; // Overfilled write
        logic full; // fifo_full_flag
        logic empty; // fifo_empty_flag
        logic frz; // Clocks stopped
        long_poly = s_r.poly_length_minus_one > pcg_pkg::POLY_LENGTH_MINUS_ONE_SHORT_MAX;
        depth = long_poly ? pcg_pkg::DEPTH_LONG : pcg_pkg::DEPTH_SHORT; // RULE5
        pmask = long_poly ? pcg_pkg::PTR_MASK_LONG : pcg_pkg::PTR_MASK_SHORT;
        wmask = pcg_pkg::ONES >> (pcg_pkg::POLY_LENGTH_MINUS_ONE_TOP - s_r.poly_length_minus_one); // RULE1
        msb_lane = long_poly;
        full = s_r.cnt == depth; // RULE10
        empty = s_r.cnt == 5'h00; // RULE10
        frz = sleep_mode | (idle_mode & s_r.sidl); // RULE17 RULE18
        s_nxt = s_r;
        s_nxt.irq = 1'b0;
        stg = s_r.stage;
        push = 1'b0;
        wrap = 1'b0;
        pop = 1'b0;

        // Register writes; byte lanes update separately
        if (bus.wr)
        begin
            if (bus.addr == pcg_pkg::ADDR_CTRL)
            begin
                if (bus.be[1])
                    s_nxt.sidl = bus.wdata[pcg_pkg::CTRL_SIDL];
                if (bus.be[0])
                begin
                    s_nxt.go = bus.wdata[pcg_pkg::CTRL_GO]; // RULE4
                    s_nxt.poly_length_minus_one = bus.wdata[pcg_pkg::CTRL_POLY_LENGTH_MINUS_ONE_MSB:0]; // RULE1
                end
            end
            else if (bus.addr == pcg_pkg::ADDR_TAPS)
            begin
                if (bus.be[1])
                    s_nxt.taps[15:8] = bus.wdata[15:8]; // RULE3
                if (bus.be[0])
                    s_nxt.taps[7:1] = bus.wdata[7:1]; // RULE3
            end
            else if (bus.addr == pcg_pkg::ADDR_RESULT)
            begin
                // Seeding the result lets software chain blocks
                if (bus.be[1])
                    s_nxt.crc[15:8] = bus.wdata[15:8];
                if (bus.be[0])
                    s_nxt.crc[7:0] = bus.wdata[7:0];
            end
            else
            begin
                if (bus.be[1])
                    stg[15:8] = bus.wdata[15:8];
                if (bus.be[0])
                    stg[7:0] = bus.wdata[7:0];
                s_nxt.stage = stg;
                push = bus.be[msb_lane]; // RULE6 RULE7
            end
        end

        wrap = push & full; // RULE11
        pop = s_r.go && (s_r.eng == PCG_ENG_IDLE) && !empty; // RULE8

        // FIFO bookkeeping; an overfilled write drops all words
        if (wrap)
        begin
            s_nxt.cnt = 5'h00; // RULE11
            s_nxt.rp = s_r.wp;
        end
        else
        begin
            if (push)
            begin
                s_nxt.fifo[s_r.wp] = stg & wmask; // RULE6
                s_nxt.wp = (s_r.wp + 4'h1) & pmask;
            end
            if (pop)
                s_nxt.rp = (s_r.rp + 4'h1) & pmask;
            s_nxt.cnt = s_r.cnt + {4'h0, push} - {4'h0, pop}; // RULE7 RULE8
            // Only a drain to zero raises the event
            s_nxt.irq = pop && !push && (s_r.cnt == 5'h01); // RULE12
        end

        // Engine: load a word, then shift two bits per clock
        case (s_r.eng)
            PCG_ENG_IDLE:
            begin
                if (pop)
                begin
                    s_nxt.sh = s_r.fifo[s_r.rp] << (pcg_pkg::POLY_LENGTH_MINUS_ONE_TOP - s_r.poly_length_minus_one); // RULE20
                    s_nxt.left = {1'b0, s_r.poly_length_minus_one} + 5'h01;
                    s_nxt.eng = PCG_ENG_SHIFT;
                end
            end
            PCG_ENG_SHIFT:
            begin
                // A cleared start bit pauses the shifter mid-word
                if (s_r.go) // RULE4
                begin
                    s_nxt.sh = s_r.sh << 2; // RULE20
                    if (s_r.left > 5'h01)
                    begin
                        s_nxt.crc = crc_two; // RULE9
                        s_nxt.left = s_r.left - 5'h02;
                    end
                    else
                    begin
                        s_nxt.crc = crc_one; // RULE9
                        s_nxt.left = 5'h00;
                    end
                    if (s_r.left <= 5'h02)
                        s_nxt.eng = PCG_ENG_IDLE;
                end
            end
            default:
                s_nxt.eng = PCG_ENG_IDLE;
        endcase

        // Read data register, one cycle after the strobe
        if (bus.rd)
        begin
            if (bus.addr == pcg_pkg::ADDR_CTRL)
                s_nxt.rdata = {2'b00, s_r.sidl, s_r.cnt, full, empty, 1'b0, s_r.go,
                    s_r.poly_length_minus_one}; // RULE19
            else if (bus.addr == pcg_pkg::ADDR_TAPS)
                s_nxt.rdata = {s_r.taps, 1'b0}; // RULE3
            else
                s_nxt.rdata = s_r.crc;
        end

        // Stopped clocks: hold everything, bus reads still answer
        if (frz)
        begin
            s_nxt = s_r; // RULE17
            s_nxt.irq = 1'b0;
            s_nxt.rdata = bus.rd ? s_nxt.rdata : s_r.rdata;
            if (bus.rd && bus.addr == pcg_pkg::ADDR_CTRL)
                s_nxt.rdata = {2'b00, s_r.sidl, s_r.cnt, full, empty, 1'b0, s_r.go,
                    s_r.poly_length_minus_one};
            else if (bus.rd && bus.addr == pcg_pkg::ADDR_TAPS)
                s_nxt.rdata = {s_r.taps, 1'b0};
            else if (bus.rd)
                s_nxt.rdata = s_r.crc;
        end
    end

    // State register; reset leaves FIFO empty and engine idle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r <= '0;
            s_r.eng <= PCG_ENG_IDLE;
        end
        else
            s_r <= s_nxt;
    end

    assign bus.rdata = s_r.rdata;
    assign crc_irq = s_r.irq;
endmodule
`default_nettype wire

/* rtl/pcg_host.sv */
// Processor-side controller that drives the generator's registers.
// Assumes the generator answers reads one cycle after the strobe.
`default_nettype none
module pcg_host (
    input wire logic core_clk, // 200 MHz clock
    input wire logic rst_b, // Async reset, active low
    pcg_if.host bus, // Register carrier
    input wire logic [1:0] u_addr, // Command index
    input wire logic [15:0] u_wdata, // Command data
    input wire logic u_wr, // Command write strobe
    input wire logic u_rd, // Status read strobe
    output logic [15:0] u_rdata // Status data, one cycle later
);
    typedef enum logic [7:0] {
        PCG_H_IDLE = 8'b0000_0001,
        PCG_H_POLL = 8'b0000_0010,
        PCG_H_RDW = 8'b0000_0100,
        PCG_H_CHECK = 8'b0000_1000,
        PCG_H_GAP = 8'b0001_0000,
        PCG_H_SETTLE = 8'b0010_0000,
        PCG_H_RESW = 8'b0100_0000,
        PCG_H_CATCH = 8'b1000_0000
    } pcg_hst_t;

    typedef struct packed {
        pcg_hst_t st; // Sequencer state
        logic [15:0] cfg; // Control shadow, go bit clear
        logic [15:0] word; // Word waiting to go out
        logic fin; // Draining rather than pushing
        logic done; // Result captured
        logic [15:0] result; // Captured checksum
        logic [3:0] wait_cnt; // Tail shift wait
        logic [15:0] urdata; // User read data
        logic [1:0] b_addr; // Bus address
        logic [15:0] b_wdata; // Bus write data
        logic b_wr; // Bus write strobe
        logic b_rd; // Bus read strobe
    } pcg_host_st_t;

    pcg_host_st_t h_r; // Registered state
    pcg_host_st_t h_nxt; // Next state

    // Sequencer and user port
    always_comb
    begin
        logic [4:0] cnt; // Count read back
        logic [4:0] depth; // Depth for read-back length
        cnt = bus.rdata[pcg_pkg::CTRL_CNT_MSB:pcg_pkg::CTRL_CNT_LSB];
        depth = (bus.rdata[pcg_pkg::CTRL_POLY_LENGTH_MINUS_ONE_MSB:0] > pcg_pkg::POLY_LENGTH_MINUS_ONE_SHORT_MAX) ?
            pcg_pkg::DEPTH_LONG : pcg_pkg::DEPTH_SHORT;
        h_nxt = h_r;
        h_nxt.b_wr = 1'b0;
        h_nxt.b_rd = 1'b0;
        if (u_rd)
            h_nxt.urdata = (u_addr == pcg_pkg::HCMD_CFG) ?
                {14'h0000, h_r.st != PCG_H_IDLE, h_r.done} : h_r.result;
        case (h_r.st)
            PCG_H_IDLE:
            begin
                // Commands while busy are dropped; status shows busy
                if (u_wr && u_addr == pcg_pkg::HCMD_CFG)
                begin
                    h_nxt.cfg = u_wdata & ~(16'h0001 << pcg_pkg::CTRL_GO);
                    h_nxt.b_addr = pcg_pkg::ADDR_CTRL;
                    h_nxt.b_wdata = h_nxt.cfg;
                    h_nxt.b_wr = 1'b1;
                    h_nxt.done = 1'b0;
                end
                else if (u_wr && u_addr == pcg_pkg::HCMD_TAPS)
                begin
                    h_nxt.b_addr = pcg_pkg::ADDR_TAPS;
                    h_nxt.b_wdata = u_wdata;
                    h_nxt.b_wr = 1'b1;
                end
                else if (u_wr && u_addr == pcg_pkg::HCMD_WORD)
                begin
                    h_nxt.word = u_wdata;
                    h_nxt.fin = 1'b0;
                    h_nxt.st = PCG_H_POLL;
                end
                else if (u_wr)
                begin
                    // Start shifting and run until empty
                    h_nxt.b_addr = pcg_pkg::ADDR_CTRL;
                    h_nxt.b_wdata = h_r.cfg | (16'h0001 << pcg_pkg::CTRL_GO); // RULE15
                    h_nxt.b_wr = 1'b1;
                    h_nxt.fin = 1'b1;
                    h_nxt.done = 1'b0;
                    h_nxt.st = PCG_H_POLL;
                end
            end
            PCG_H_POLL:
            begin
                h_nxt.b_addr = pcg_pkg::ADDR_CTRL;
                h_nxt.b_rd = 1'b1;
                h_nxt.st = PCG_H_RDW;
            end
            PCG_H_RDW:
                h_nxt.st = PCG_H_CHECK;
            PCG_H_CHECK:
            begin
                if (h_r.fin)
                begin
                    // Empty flag first, then the tail of the last word
                    if (bus.rdata[pcg_pkg::CTRL_EMPTY]) // RULE13
                    begin
                        h_nxt.wait_cnt = pcg_pkg::SETTLE_CYC;
                        h_nxt.st = PCG_H_SETTLE;
                    end
                    else
                        h_nxt.st = PCG_H_POLL;
                end
                else if (cnt < depth) // RULE16
                begin
                    h_nxt.b_addr = pcg_pkg::ADDR_DATA;
                    h_nxt.b_wdata = h_r.word;
                    h_nxt.b_wr = 1'b1;
                    h_nxt.st = PCG_H_GAP;
                end
                else
                    h_nxt.st = PCG_H_POLL;
            end
            PCG_H_GAP:
                h_nxt.st = PCG_H_IDLE; // RULE14
            PCG_H_SETTLE:
            begin
                if (h_r.wait_cnt == 4'h0)
                begin
                    h_nxt.b_addr = pcg_pkg::ADDR_RESULT;
                    h_nxt.b_rd = 1'b1;
                    h_nxt.st = PCG_H_RESW;
                end
                else
                    h_nxt.wait_cnt = h_r.wait_cnt - 4'h1;
            end
            PCG_H_RESW:
                h_nxt.st = PCG_H_CATCH;
            PCG_H_CATCH:
            begin
                h_nxt.result = bus.rdata; // RULE13
                h_nxt.done = 1'b1;
                h_nxt.st = PCG_H_IDLE;
            end
            default:
                h_nxt.st = PCG_H_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            h_r <= '0;
            h_r.st <= PCG_H_IDLE;
        end
        else
            h_r <= h_nxt;
    end

    assign bus.addr = h_r.b_addr;
    assign bus.wdata = h_r.b_wdata;
    assign bus.be = 2'b11;
    assign bus.wr = h_r.b_wr;
    assign bus.rd = h_r.b_rd;
    assign u_rdata = h_r.urdata;
endmodule
`default_nettype wire

/* tb/pcg_checker.sv */
// Assertions on the register carrier between the host and the generator.
// Instantiated beside the carrier in the bench; one clock, async reset.
`default_nettype none
module pcg_checker (
    input wire logic core_clk, // 200 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [1:0] addr, // Register index
    input wire logic [15:0] wdata, // Write data, spare control bits judged
    input wire logic [1:0] be, // Byte lanes, whole words expected
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic [15:0] rdata, // Read data, cycle after rd
    input wire logic crc_irq, // Interrupt pulse
    input wire logic sleep_mode // Device asleep
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    logic ctl_rd_r; // A control read is being answered now
    logic last_empty_r; // Empty flag of the latest control answer
    logic [4:0] cnt; // Count field of the answer
    logic [4:0] depth; // Depth implied by the length in the answer
    assign cnt = rdata[12:8];
    assign depth = (rdata[3:0] > pcg_pkg::POLY_LENGTH_MINUS_ONE_SHORT_MAX) ? pcg_pkg::DEPTH_LONG
        : pcg_pkg::DEPTH_SHORT;
    // Keep the last empty flag, so a result read can be judged later
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_rd_r <= 1'b0;
            last_empty_r <= 1'b0;
        end
        else
        begin
            ctl_rd_r <= rd && (addr == pcg_pkg::ADDR_CTRL);
            if (ctl_rd_r)
                last_empty_r <= rdata[pcg_pkg::CTRL_EMPTY];
        end
    end
    a_empty_count:
        assert property (ctl_rd_r |-> rdata[6] == (cnt == 5'h00)) else $error("empty flag wrong");
    a_full_depth:
        assert property (ctl_rd_r |-> rdata[7] == (cnt == depth)) else $error("full flag wrong");
    a_count_bound:
        assert property (ctl_rd_r |-> cnt <= depth) else $error("count above depth");
    a_ctrl_spare:
        assert property (ctl_rd_r |-> rdata[15:14] == 2'b00 && !rdata[5])
        else $error("spare control bits set");
    a_irq_single:
        assert property (crc_irq |=> !crc_irq) else $error("interrupt longer than a cycle");
    a_sleep_quiet:
        assert property (sleep_mode && $past(sleep_mode) |-> !crc_irq)
        else $error("interrupt while frozen");
    a_count_gap:
        assert property (wr && addr == pcg_pkg::ADDR_DATA |=> !(rd && addr == pcg_pkg::ADDR_CTRL))
        else $error("count read right after data write");
    a_result_ready:
        assert property (rd && addr == pcg_pkg::ADDR_RESULT |-> last_empty_r)
        else $error("result read before empty");
    // The host writes whole words only, never with a read, spare bits clear
    a_write_lanes:
        assert property (wr |-> be == 2'b11 && !rd
            && (addr != pcg_pkg::ADDR_CTRL || wdata[15:14] == 2'b00))
        else $error("partial or overlapping write");
endmodule
`default_nettype wire

/* tb/tb_programmable_crc_generator.sv */
// Bench: host controller and generator joined by the carrier, driven on the user port.
// Assumes status reads answer one cycle after the strobe and never stall.
`default_nettype none
module tb_programmable_crc_generator;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0; // 200 MHz clock
    logic rst_b = 1'b0; // Reset, active low
    logic sleep_mode = 1'b0; // Device asleep
    logic idle_mode = 1'b0; // Device idle
    logic [1:0] u_addr = 2'h0; // Host command index
    logic [15:0] u_wdata = 16'h0000; // Host command data
    logic u_wr = 1'b0; // Host command strobe
    logic u_rd = 1'b0; // Host status strobe
    logic [15:0] u_rdata; // Host status data
    logic crc_irq; // Generator interrupt
    int num_errors = 0; // Mismatches seen
    int tests_run = 0; // Comparisons made
    int irq_seen = 0; // Interrupt pulses so far
    pcg_if pcg_if_inst ();
    pcg_dev pcg_dev_inst (.core_clk(core_clk), .rst_b(rst_b), .bus(pcg_if_inst.dev),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode), .crc_irq(crc_irq));
    pcg_host pcg_host_inst (.core_clk(core_clk), .rst_b(rst_b), .bus(pcg_if_inst.host),
        .u_addr(u_addr), .u_wdata(u_wdata), .u_wr(u_wr), .u_rd(u_rd), .u_rdata(u_rdata));
    pcg_checker pcg_checker_inst (.core_clk(core_clk), .rst_b(rst_b), .addr(pcg_if_inst.addr),
        .wdata(pcg_if_inst.wdata), .be(pcg_if_inst.be), .wr(pcg_if_inst.wr),
        .rd(pcg_if_inst.rd), .rdata(pcg_if_inst.rdata), .crc_irq(crc_irq),
        .sleep_mode(sleep_mode));
    always #2.5 core_clk = ~core_clk;
    // Count pulses so each run can expect exactly one
    always @(posedge core_clk)
    begin
        if (crc_irq === 1'b1)
            irq_seen++;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        tests_run++;
        if (seen !== expected)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expected);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One-cycle command strobe; the edge that takes it also drops it
    task automatic issue(input logic [1:0] a, input logic [15:0] d);
        @(posedge core_clk);
        u_addr <= a;
        u_wdata <= d;
        u_wr <= 1'b1;
        @(posedge core_clk);
        u_wr <= 1'b0;
    endtask
    task automatic uread(input logic [1:0] a, output logic [15:0] v);
        @(posedge core_clk);
        u_addr <= a;
        u_rd <= 1'b1;
        @(posedge core_clk);
        u_rd <= 1'b0;
        #1 v = u_rdata;
    endtask
    // Poll busy under a bound; a stuck host ends the run
    task automatic wait_idle();
        logic [15:0] s;
        s = 16'h0002;
        for (int n = 0; n < 200 && s[1]; n++)
            uread(pcg_pkg::HCMD_CFG, s);
        if (s[1] !== 1'b0)
        begin
            num_errors++;
            $display("unexpected at %0t: host stuck busy", $time);
            test_done();
        end
    endtask
    task automatic do_reset();
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask
    function automatic logic [15:0] word_at(input int i);
        return 16'hC3A5 ^ 16'(i * 32'h0000_2F1B);
    endfunction
    // Reference: msb first, feedback from the top bit, constant term always in
    function automatic logic [15:0] crc_model(input logic [3:0] poly_length_minus_one, input logic [15:0] taps,
        input int n);
        logic [15:0] c, w, m;
        logic fb;
        c = 16'h0000;
        m = pcg_pkg::ONES >> (4'hF - poly_length_minus_one);
        for (int i = 0; i < n; i++)
        begin
            w = word_at(i) & m;
            for (int b = 15; b >= 0; b--)
            begin
                if (b <= poly_length_minus_one)
                begin
                    fb = c[poly_length_minus_one] ^ w[b];
                    c = ((c << 1) & m) ^ (fb ? ((taps | 16'h0001) & m) : 16'h0000);
                end
            end
        end
        return c;
    endfunction
    // Mode: 0 run, 1 sleep, 2 idle with stop bit, 3 idle without it
    task automatic run_calc(input logic [3:0] poly_length_minus_one, input logic [15:0] taps, input int n,
        input int mode);
        logic [15:0] m, v;
        int irq_base;
        m = pcg_pkg::ONES >> (4'hF - poly_length_minus_one);
        irq_base = irq_seen;
        do_reset();
        issue(pcg_pkg::HCMD_CFG, {2'b00, mode == 2, 9'h000, poly_length_minus_one});
        wait_idle();
        issue(pcg_pkg::HCMD_TAPS, taps);
        wait_idle();
        for (int i = 0; i < n; i++)
        begin
            issue(pcg_pkg::HCMD_WORD, word_at(i));
            wait_idle();
        end
        issue(pcg_pkg::HCMD_FINISH, 16'h0000);
        repeat (4) @(posedge core_clk);
        sleep_mode <= (mode == 1);
        idle_mode <= (mode >= 2);
        // Long enough for a free-running drain to finish well before the look
        repeat (120) @(posedge core_clk);
        uread(pcg_pkg::HCMD_CFG, v);
        check({15'h0000, v[1]}, {15'h0000, mode == 1 || mode == 2});
        @(posedge core_clk);
        sleep_mode <= 1'b0;
        idle_mode <= 1'b0;
        wait_idle();
        uread(pcg_pkg::HCMD_CFG, v);
        check(v, 16'h0001);
        uread(pcg_pkg::HCMD_TAPS, v);
        check(v & m, crc_model(poly_length_minus_one, taps, n));
        check(16'(irq_seen - irq_base), 16'h0001);
    endtask
    initial
    begin
        do_reset();
        run_calc(4'hF, 16'h1020, 8, 0);
        run_calc(4'h7, 16'h0006, 12, 0);
        run_calc(4'h4, 16'h0004, 3, 0);
        run_calc(4'hF, 16'h1020, 8, 1);
        run_calc(4'hF, 16'h8005, 8, 2);
        run_calc(4'h9, 16'h0230, 5, 3);
        test_done();
    end
endmodule
`default_nettype wire
